/* core/cwd_pkg.sv */
// Overview of operation
// [RULE_01] frequency mode: low compare match toggles pin, low compare += high compare
// [RULE_02] frequency mode: high compare of zero means a half period of 256 ticks
// [RULE_03] frequency mode when compare, toggle and pwm enables are all set
// [RULE_04] low compare write clears compare enable, high compare write sets it
// [RULE_05] 8-bit pwm: pin high on low byte match, low on low byte overflow
// [RULE_06] 8-bit pwm: low byte overflow reloads low compare from high compare
// [RULE_07] 8-bit pwm when compare and pwm enables set, wide select clear
// [RULE_08] 8-bit duty is (256 - high compare)/256; compare disabled gives low
// [RULE_09] 16-bit pwm: pin high on full match, low on counter overflow
// [RULE_10] 16-bit pwm when compare, pwm and wide select bits are set
// [RULE_11] 16-bit duty is (65536 - compare)/65536; zero gives constant high
// [RULE_12] software times 16-bit compare updates to the match event
// [RULE_13] watchdog on: module 5 high compares counter high, low is offset
// [RULE_14] after reset: watchdog on, clock/12, counter and offset zero
// [RULE_15] watchdog on: counter runs, counter, timebase, idle, module 5 mode writes ignored
// [RULE_16] watchdog on: run bit writes do not stop counting; reads stored bit
// [RULE_17] any write to update byte loads counter high plus offset
// [RULE_18] watchdog reset on low byte overflow while update byte equals counter high
// [RULE_19] watchdog on: writing one to module 5 flag forces watchdog reset
// [RULE_20] enable or lock turns watchdog on; lock holds it until reset
// [RULE_21] software disables, configures, re-enables, then refreshes the watchdog
// [RULE_22] timebase select: /12, /4, timer 0, count input falls, clock, osc/8
// [RULE_23] module event flags stay set until software clears them
// [RULE_24] counter steps once per timebase tick, all modules see one value
package cwd_pkg;
  localparam int NMOD   = 6;
  localparam int WD_MOD = 5;

  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TBMD = 8'h04;
  localparam logic [7:0] A_CNT  = 8'h08;
  localparam logic [7:0] A_MOD0 = 8'h10;
  localparam logic [7:0] A_CMP0 = 8'h30;

  // field positions
  localparam int CB_RUN  = 6;
  localparam int MD_TB0  = 1;
  localparam int MD_LOCK = 5;
  localparam int MD_WDE  = 6;
  localparam int MD_IDLE = 7;
  localparam int MB_PWM  = 1;
  localparam int MB_TOG  = 3;
  localparam int MB_CE   = 6;
  localparam int MB_WIDE = 7;

  // timebase dividers
  localparam logic [3:0] PRESC_MAX = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] OSC_LAST  = 3'h7;
  localparam logic [7:0] LOW_MAX   = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TB_DIV12 = 3'h0,
    TB_DIV4  = 3'h1,
    TB_T0OVF = 3'h2,
    TB_ECI   = 3'h3,
    TB_SYS   = 3'h4,
    TB_OSC8  = 3'h5
  } cwd_tb_e;

  typedef enum logic [1:0] {
    OM_OFF   = 2'h0,
    OM_FREQ  = 2'h1,
    OM_PWM16 = 2'h3,
    OM_PWM8  = 2'h2
  } cwd_om_e;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } cwd_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cwd_axil_rsp_s;

  typedef struct packed {
    logic [3:0]             presc;
    logic [2:0]             external_count_input;
    logic [2:0]             osc;
    logic [2:0]             oscDiv;
    logic [15:0]            cnt;
    logic                   run;
    logic [2:0]             tbSel;
    logic                   idleHalt;
    logic                   wdeBit;
    logic                   lockBit;
    logic [NMOD-1:0]        flags;
    logic [NMOD-1:0][7:0]   mode;
    logic [NMOD-1:0][7:0]   cmpL;
    logic [NMOD-1:0][7:0]   cmpH;
    logic [NMOD-1:0]        pin;
    logic                   wdRst;
    logic                   awHeld;
    logic [7:0]             awAddr;
    logic                   wHeld;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } cwd_state_s;
endpackage

/* core/cwd_counter_array.sv */
`timescale 1ns/10ps
module cwd_counter_array (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // register bus
  input  wire cwd_pkg::cwd_axil_req_s axi,
  output      cwd_pkg::cwd_axil_rsp_s axiRsp,
  // timebase sources, and the cpu idle input that can halt the counter
  input  wire logic                   timer0Ovf,
  input  wire logic                   extCountPin,
  input  wire logic                   extOscPin,
  input  wire logic                   cpuIdle,
  // outputs
  output      logic [5:0]             modulePin,
  output      logic                   watchdogReset
);

  cwd_pkg::cwd_state_s s_r;
  cwd_pkg::cwd_state_s s_nxt;

  logic                   wdEn;
  logic                   tick;
  logic                   go;
  logic                   ovf;
  logic                   doWr;
  logic                   wdm;
  logic [15:0]            nc;
  logic [7:0]             cl;
  logic [7:0]             wa;
  logic [31:0]            wd;
  logic [3:0]             mIdx;
  logic [3:0]             cIdx;
  logic [3:0]             rmIdx;
  logic [3:0]             rcIdx;
  logic [cwd_pkg::NMOD-1:0] evts;
  cwd_pkg::cwd_om_e       om;

  // index of a per-module register, or all ones when outside the group
  function automatic logic [3:0] modSel(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d[1:0] == 2'h0 && d < 8'(4 * cwd_pkg::NMOD))
      modSel = {1'b0, d[4:2]};
    else
      modSel = 4'hf;
  endfunction

  function automatic cwd_pkg::cwd_om_e modeOf(input logic [7:0] m);
    if (!m[cwd_pkg::MB_CE] || !m[cwd_pkg::MB_PWM])
      modeOf = cwd_pkg::OM_OFF; // RULE_08
    else if (m[cwd_pkg::MB_TOG])
      modeOf = cwd_pkg::OM_FREQ; // RULE_03
    else if (m[cwd_pkg::MB_WIDE])
      modeOf = cwd_pkg::OM_PWM16; // RULE_10
    else
      modeOf = cwd_pkg::OM_PWM8; // RULE_07
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign wdEn  = s_r.wdeBit | s_r.lockBit; // RULE_20
  assign doWr  = s_r.awHeld && s_r.wHeld && !s_r.bvalid;
  assign rmIdx = modSel(axi.araddr[7:0], cwd_pkg::A_MOD0);
  assign rcIdx = modSel(axi.araddr[7:0], cwd_pkg::A_CMP0);

  assign axiRsp = '{
    awready: !s_r.awHeld && !s_r.bvalid,
    wready:  !s_r.wHeld && !s_r.bvalid,
    bvalid:  s_r.bvalid,
    bresp:   s_r.bresp,
    arready: !s_r.rvalid,
    rvalid:  s_r.rvalid,
    rdata:   s_r.rdata,
    rresp:   s_r.rresp
  };

  assign modulePin     = s_r.pin;
  assign watchdogReset = s_r.wdRst;

  always_comb
  begin
    s_nxt = s_r;
    cl    = 8'h00;
    evts  = '0;
    om    = cwd_pkg::OM_OFF;
    wdm   = 1'b0;
    wa    = s_r.awAddr;
    wd    = s_r.wData;
    mIdx  = modSel(wa, cwd_pkg::A_MOD0);
    cIdx  = modSel(wa, cwd_pkg::A_CMP0);

    // pins from other clocks: first stage feeds only the second
    s_nxt.external_count_input = {s_r.external_count_input[1:0], extCountPin};
    s_nxt.osc = {s_r.osc[1:0], extOscPin};
    s_nxt.presc = (s_r.presc == cwd_pkg::PRESC_MAX) ? 4'h0 : s_r.presc + 4'h1;
    if (s_r.osc[1] && !s_r.osc[2])
      s_nxt.oscDiv = s_r.oscDiv + 3'h1;

    unique case (cwd_pkg::cwd_tb_e'(s_r.tbSel)) // RULE_22
      cwd_pkg::TB_DIV12: tick = (s_r.presc == cwd_pkg::PRESC_MAX);
      cwd_pkg::TB_DIV4:  tick = (s_r.presc[1:0] == cwd_pkg::DIV4_LAST);
      cwd_pkg::TB_T0OVF: tick = timer0Ovf;
      cwd_pkg::TB_ECI:   tick = s_r.external_count_input[2] && !s_r.external_count_input[1];
      cwd_pkg::TB_SYS:   tick = 1'b1;
      cwd_pkg::TB_OSC8:  tick = s_r.osc[1] && !s_r.osc[2] && s_r.oscDiv == cwd_pkg::OSC_LAST;
      default:           tick = 1'b0;
    endcase

    // watchdog keeps the counter running whatever the run bit says
    go  = tick && (s_r.run || wdEn) && !(s_r.idleHalt && cpuIdle); // RULE_15 RULE_16
    nc  = s_r.cnt + 16'h0001;
    ovf = go && nc[7:0] == 8'h00;
    if (go)
      s_nxt.cnt = nc; // RULE_24

    // every module works from the same next count
    for (int i = 0; i < cwd_pkg::NMOD; i++)
    begin
      om = modeOf(s_r.mode[i]);
      if (i == cwd_pkg::WD_MOD && wdEn)
        om = cwd_pkg::OM_OFF; // RULE_15
      unique case (om)
        cwd_pkg::OM_FREQ:
          if (go && nc[7:0] == s_r.cmpL[i])
          begin
            s_nxt.pin[i]  = !s_r.pin[i]; // RULE_01
            // a zero step wraps all the way round: 256 ticks
            s_nxt.cmpL[i] = s_r.cmpL[i] + s_r.cmpH[i]; // RULE_01 RULE_02
            evts[i]       = 1'b1;
          end
        cwd_pkg::OM_PWM8:
          if (go)
          begin
            cl = ovf ? s_r.cmpH[i] : s_r.cmpL[i]; // RULE_06
            s_nxt.cmpL[i] = cl;
            if (nc[7:0] == cl)
            begin
              s_nxt.pin[i] = 1'b1; // RULE_05 RULE_08
              evts[i]      = 1'b1;
            end
            else if (ovf)
              s_nxt.pin[i] = 1'b0; // RULE_05
          end
        cwd_pkg::OM_PWM16:
          if (go)
          begin
            if (nc == {s_r.cmpH[i], s_r.cmpL[i]})
            begin
              s_nxt.pin[i] = 1'b1; // RULE_09 RULE_11
              evts[i]      = 1'b1;
            end
            else if (nc == 16'h0000)
              s_nxt.pin[i] = 1'b0; // RULE_09
          end
        default:
          s_nxt.pin[i] = 1'b0; // RULE_08
      endcase
    end

    // timeout: low byte rolls over while update byte equals counter high
    s_nxt.wdRst = wdEn && ovf &&
                  s_r.cmpH[cwd_pkg::WD_MOD] == s_r.cnt[15:8]; // RULE_13 RULE_18

    ////////////////////////////////////////////////////////////////////////
    // bus slave: address and data may arrive in either order
    if (axi.awvalid && !s_r.awHeld && !s_r.bvalid)
    begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = axi.awaddr[7:0];
    end
    if (axi.wvalid && !s_r.wHeld && !s_r.bvalid)
    begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = axi.wdata;
      s_nxt.wStrb = axi.wstrb;
    end
    if (s_r.bvalid && axi.bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && axi.rready)
      s_nxt.rvalid = 1'b0;

    if (doWr)
    begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = cwd_pkg::RESP_OKAY;
      if (wa == cwd_pkg::A_CTRL)
      begin
        if (s_r.wStrb[0])
        begin
          s_nxt.flags = wd[cwd_pkg::NMOD-1:0];
          s_nxt.run   = wd[cwd_pkg::CB_RUN];
          if (wdEn && wd[cwd_pkg::WD_MOD])
            s_nxt.wdRst = 1'b1; // RULE_19
        end
      end
      else if (wa == cwd_pkg::A_TBMD)
      begin
        if (s_r.wStrb[0])
        begin
          s_nxt.lockBit = s_r.lockBit | wd[cwd_pkg::MD_LOCK]; // RULE_20
          s_nxt.wdeBit  = wd[cwd_pkg::MD_WDE];
          if (!wdEn)
          begin
            s_nxt.tbSel    = wd[cwd_pkg::MD_TB0 +: 3]; // RULE_15
            s_nxt.idleHalt = wd[cwd_pkg::MD_IDLE];
          end
        end
      end
      else if (wa == cwd_pkg::A_CNT)
      begin
        if (!wdEn && s_r.wStrb[0])
          s_nxt.cnt[7:0] = wd[7:0]; // RULE_15
        if (!wdEn && s_r.wStrb[1])
          s_nxt.cnt[15:8] = wd[15:8];
      end
      else if (mIdx != 4'hf)
      begin
        if (s_r.wStrb[0] && !(mIdx == 4'(cwd_pkg::WD_MOD) && wdEn))
          s_nxt.mode[mIdx[2:0]] = wd[7:0]; // RULE_15
      end
      else if (cIdx != 4'hf)
      begin
        wdm = (cIdx == 4'(cwd_pkg::WD_MOD)) && wdEn;
        if (s_r.wStrb[0])
        begin
          s_nxt.cmpL[cIdx[2:0]] = wd[7:0];
          if (!wdm)
            s_nxt.mode[cIdx[2:0]][cwd_pkg::MB_CE] = 1'b0; // RULE_04
        end
        if (s_r.wStrb[1])
        begin
          if (wdm)
            s_nxt.cmpH[cIdx[2:0]] = 8'(s_r.cnt[15:8] + s_nxt.cmpL[cIdx[2:0]]); // RULE_17
          else
          begin
            s_nxt.cmpH[cIdx[2:0]] = wd[15:8];
            s_nxt.mode[cIdx[2:0]][cwd_pkg::MB_CE] = 1'b1; // RULE_04
          end
        end
      end
      else
        s_nxt.bresp = cwd_pkg::RESP_SLVERR;
    end

    // a match in the same cycle as a clearing write still lands
    s_nxt.flags = s_nxt.flags | evts; // RULE_23

    if (axi.arvalid && !s_r.rvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = 32'h0000_0000;
      s_nxt.rresp  = cwd_pkg::RESP_OKAY;
      if (axi.araddr[7:0] == cwd_pkg::A_CTRL)
        s_nxt.rdata[cwd_pkg::CB_RUN:0] = {s_r.run, s_r.flags}; // RULE_16
      else if (axi.araddr[7:0] == cwd_pkg::A_TBMD)
      begin
        s_nxt.rdata[cwd_pkg::MD_IDLE]     = s_r.idleHalt;
        s_nxt.rdata[cwd_pkg::MD_WDE]      = s_r.wdeBit;
        s_nxt.rdata[cwd_pkg::MD_LOCK]     = s_r.lockBit;
        s_nxt.rdata[cwd_pkg::MD_TB0 +: 3] = s_r.tbSel;
      end
      else if (axi.araddr[7:0] == cwd_pkg::A_CNT)
        s_nxt.rdata[15:0] = s_r.cnt;
      else if (rmIdx != 4'hf)
        s_nxt.rdata[7:0] = s_r.mode[rmIdx[2:0]];
      else if (rcIdx != 4'hf)
        s_nxt.rdata[15:0] = {s_r.cmpH[rcIdx[2:0]], s_r.cmpL[rcIdx[2:0]]};
      else
        s_nxt.rresp = cwd_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_r        <= '0;
      s_r.wdeBit <= 1'b1; // RULE_14
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_wdExpire;
    wdEn && ovf && s_r.cmpH[cwd_pkg::WD_MOD] == s_r.cnt[15:8];
  endsequence

  sequence s_wdForce;
    doWr && wa == cwd_pkg::A_CTRL && s_r.wStrb[0] && wd[cwd_pkg::WD_MOD] && wdEn;
  endsequence

  property p_wdTimeout;
    s_wdExpire |=> watchdogReset;
  endproperty
  a_wdTimeout: assert property (p_wdTimeout) else $error("watchdog expiry without reset"); // RULE_18

  property p_wdForce;
    s_wdForce |=> watchdogReset;
  endproperty
  a_wdForce: assert property (p_wdForce) else $error("forced watchdog reset missing"); // RULE_19

  property p_wdCause;
    watchdogReset |-> $past(wdEn);
  endproperty
  a_wdCause: assert property (p_wdCause) else $error("reset with watchdog off"); // RULE_18

  property p_resetState;
    $fell(rst) |-> wdEn && s_r.tbSel == 3'h0 && s_r.cnt == 16'h0000 &&
                   s_r.cmpL[cwd_pkg::WD_MOD] == 8'h00;
  endproperty
  a_resetState: assert property (p_resetState) else $error("bad state after reset"); // RULE_14

  property p_lockHolds;
    s_r.lockBit |=> s_r.lockBit && wdEn;
  endproperty
  a_lockHolds: assert property (p_lockHolds) else $error("lock dropped"); // RULE_20

  property p_cntFrozenSel;
    wdEn |=> s_r.tbSel == $past(s_r.tbSel) && s_r.idleHalt == $past(s_r.idleHalt);
  endproperty
  a_cntFrozenSel: assert property (p_cntFrozenSel) else $error("timebase changed"); // RULE_15

  property p_freqToggle;
    modeOf(s_r.mode[1]) == cwd_pkg::OM_FREQ && go && nc[7:0] == s_r.cmpL[1] && !doWr
      |=> modulePin[1] != $past(modulePin[1]) &&
          s_r.cmpL[1] == 8'($past(s_r.cmpL[1]) + $past(s_r.cmpH[1]));
  endproperty
  a_freqToggle: assert property (p_freqToggle) else $error("frequency step wrong"); // RULE_01

  property p_pwm8Reload;
    modeOf(s_r.mode[0]) == cwd_pkg::OM_PWM8 && go && s_r.cnt[7:0] == cwd_pkg::LOW_MAX && !doWr
      |=> s_r.cmpL[0] == $past(s_r.cmpH[0]);
  endproperty
  a_pwm8Reload: assert property (p_pwm8Reload) else $error("pwm8 reload missing"); // RULE_06

  property p_pwm16High;
    modeOf(s_r.mode[2]) == cwd_pkg::OM_PWM16 && go && nc == {s_r.cmpH[2], s_r.cmpL[2]}
      |=> modulePin[2] ##1 modulePin[2] || $past(go);
  endproperty
  a_pwm16High: assert property (p_pwm16High) else $error("pwm16 not high on match"); // RULE_09

  property p_offLow;
    !s_r.mode[0][cwd_pkg::MB_CE] ##1 !s_r.mode[0][cwd_pkg::MB_CE] |-> !modulePin[0];
  endproperty
  a_offLow: assert property (p_offLow) else $error("disabled module drives high"); // RULE_08

  property p_flagSticky;
    s_r.flags[0] && !doWr |=> s_r.flags[0];
  endproperty
  a_flagSticky: assert property (p_flagSticky) else $error("flag cleared by hardware"); // RULE_23

endmodule

/* sim/cwd_reset_partner.sv */
`timescale 1ns/10ps
module cwd_reset_partner #(
  parameter int RST_DELAY = 4,
  parameter int RST_LEN   = 3
) (
  // clock and power-on reset
  input  wire logic ref_clk,
  input  wire logic porRst,
  // from the block
  input  wire logic watchdogReset,
  // to the system
  output      logic sysRst,
  output      int   pulseCount
);
  int delayCnt;
  int holdCnt;

  ////////////////////////////////////////////////////////////////////////////////
  // reset logic reacts late so a bus response in flight still completes
  always @(posedge ref_clk)
  begin
    if (porRst)
    begin
      delayCnt <= 0;
      holdCnt <= 0;
      pulseCount <= 0;
    end
    else
    begin
      if (watchdogReset)
      begin
        pulseCount <= pulseCount + 1;
        delayCnt <= RST_DELAY;
      end
      else if (delayCnt > 0)
        delayCnt <= delayCnt - 1;
      if (delayCnt == 1)
        holdCnt <= RST_LEN;
      else if (holdCnt > 0)
        holdCnt <= holdCnt - 1;
    end
  end

  assign sysRst = holdCnt > 0;
endmodule

/* sim/cwd_counter_array_test.sv */
`timescale 1ns/10ps
module cwd_counter_array_test;
  logic                   ref_clk;
  logic                   rstB;
  logic                   rst;
  logic                   sysRst;
  logic                   t0Ovf;
  logic                   eciPin;
  logic                   oscPin;
  logic                   idle;
  cwd_pkg::cwd_axil_req_s req;
  cwd_pkg::cwd_axil_rsp_s rsp;
  logic [5:0]             modulePin;
  logic                   watchdogReset;
  int                     pulseCount;
  int                     cyc;
  int                     fails;
  int                     num_checks;

  assign rst = rstB | sysRst;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= rst ? 0 : cyc + 1;

  // timebase sources: timer overflow every 5 cycles, count pin period 8, oscillator period 2
  always @(posedge ref_clk)
  begin
    t0Ovf <= (cyc % 5 == 0);
    eciPin <= cyc[2];
    oscPin <= cyc[0];
  end

  cwd_counter_array dut_u (.ref_clk(ref_clk), .rst(rst), .axi(req), .axiRsp(rsp),
    .timer0Ovf(t0Ovf), .extCountPin(eciPin), .extOscPin(oscPin), .cpuIdle(idle),
    .modulePin(modulePin), .watchdogReset(watchdogReset));
  cwd_reset_partner part_u (.ref_clk(ref_clk), .porRst(rstB), .watchdogReset(watchdogReset),
    .sysRst(sysRst), .pulseCount(pulseCount));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic hang;
    chk(32'h0, 32'h1);
    close_out();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // readies are judged at the falling edge, just before the edge that takes the item
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    int n;
    logic awT;
    logic wT;
    logic bT;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    n = 0;
    bT = 1'b0;
    while (!bT)
    begin
      @(negedge ref_clk);
      awT = req.awvalid && rsp.awready;
      wT = req.wvalid && rsp.wready;
      bT = rsp.bvalid === 1'b1;
      r = rsp.bresp;
      @(posedge ref_clk);
      if (awT) req.awvalid <= 1'b0;
      if (wT) req.wvalid <= 1'b0;
      if (bT) req.bready <= 1'b0;
      n++;
      if (n > 50) hang();
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic arT;
    logic rT;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    req.rready <= 1'b1;
    n = 0;
    rT = 1'b0;
    while (!rT)
    begin
      @(negedge ref_clk);
      arT = req.arvalid && rsp.arready;
      rT = rsp.rvalid === 1'b1;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge ref_clk);
      if (arT) req.arvalid <= 1'b0;
      if (rT) req.rready <= 1'b0;
      n++;
      if (n > 50) hang();
    end
  endtask

  task automatic high_count(input int m, input int len, output int hc);
    hc = 0;
    repeat (len)
    begin
      @(negedge ref_clk);
      if (modulePin[m] === 1'b1) hc++;
    end
  endtask

  task automatic wait_pin(input int m, input logic v, input int lim, output int n);
    n = 0;
    while (modulePin[m] !== v)
    begin
      @(negedge ref_clk);
      n++;
      if (n > lim) hang();
    end
  endtask

  task automatic wait_pulse(input int lim);
    int n;
    n = 0;
    while (watchdogReset !== 1'b1)
    begin
      @(negedge ref_clk);
      n++;
      if (n > lim) hang();
    end
  endtask

  task automatic wait_sys_reset;
    int n;
    n = 0;
    while (rst !== 1'b1)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 20) hang();
    end
    while (rst !== 1'b0)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 40) hang();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    logic [31:0] d;
    logic [1:0]  r;
    axr(cwd_pkg::A_TBMD, d, r); chk(d, 32'h40);
    axr(cwd_pkg::A_CTRL, d, r); chk(d, 32'h0);
    axw(cwd_pkg::A_TBMD, 32'h48, 4'h1, r);
    axr(cwd_pkg::A_TBMD, d, r); chk(d, 32'h40);
    axw(cwd_pkg::A_CNT, 32'hab12, 4'h3, r);
    axr(cwd_pkg::A_CNT, d, r); chk({24'h0, d[15:8]}, 32'h0);
    axw(cwd_pkg::A_CTRL, 32'h0, 4'h1, r);
    axw(8'hfc, 32'h1, 4'hf, r); chk({30'h0, r}, {30'h0, cwd_pkg::RESP_SLVERR});
    axr(8'hfc, d, r); chk({30'h0, r}, {30'h0, cwd_pkg::RESP_SLVERR});
    // counter keeps going although run was written low
    wait_pulse(4000); chk_rng(cyc, 3072, 3090);
    wait_sys_reset();
    $display("test defaults done");
  endtask

  task automatic t_lock;
    logic [1:0] r;
    int         p0;
    axw(cwd_pkg::A_TBMD, 32'h20, 4'h1, r);
    p0 = pulseCount;
    axw(cwd_pkg::A_CTRL, 32'h20, 4'h1, r);
    repeat (3) @(negedge ref_clk);
    chk_rng(pulseCount, p0 + 1, p0 + 1);
    wait_sys_reset();
    $display("test lock done");
  endtask

  task automatic wd_off;
    logic [31:0] d;
    logic [1:0]  r;
    int          p0;
    // system clock timebase so a pwm period is 256 cycles; select only once disabled
    axw(cwd_pkg::A_TBMD, 32'h00, 4'h1, r);
    axw(cwd_pkg::A_TBMD, 32'h08, 4'h1, r);
    axr(cwd_pkg::A_TBMD, d, r); chk(d, 32'h08);
    p0 = pulseCount;
    axw(cwd_pkg::A_CTRL, 32'h60, 4'h1, r);
    axw(cwd_pkg::A_CTRL, 32'h40, 4'h1, r);
    chk_rng(pulseCount, p0, p0);
    $display("test disable done");
  endtask

  task automatic t_pwm8;
    logic [7:0]  hv [3] = '{8'h00, 8'h40, 8'hff};
    logic [31:0] d;
    logic [1:0]  r;
    int          hc;
    for (int i = 0; i < 3; i++)
    begin
      axw(cwd_pkg::A_CMP0, 32'h0, 4'h1, r);
      axw(cwd_pkg::A_CMP0, {16'h0, hv[i], 8'h0}, 4'h2, r);
      axw(cwd_pkg::A_MOD0, 32'h42, 4'h1, r);
      repeat (300) @(negedge ref_clk);
      high_count(0, 256, hc); chk_rng(hc, 256 - hv[i], 256 - hv[i]);
      axr(cwd_pkg::A_CMP0, d, r); chk(d, {16'h0, hv[i], hv[i]});
    end
    axr(cwd_pkg::A_CTRL, d, r); chk(d, 32'h41);
    axw(cwd_pkg::A_CMP0, 32'h0, 4'h1, r);
    axr(cwd_pkg::A_MOD0, d, r); chk(d, 32'h02);
    high_count(0, 256, hc); chk_rng(hc, 0, 0);
    axw(cwd_pkg::A_CMP0, 32'h4000, 4'h2, r);
    axr(cwd_pkg::A_MOD0, d, r); chk(d, 32'h42);
    $display("test pwm8 done");
  endtask

  task automatic t_freq;
    logic [7:0] hv [2] = '{8'h10, 8'h00};
    logic [1:0] r;
    logic       v0;
    int         n;
    for (int i = 0; i < 2; i++)
    begin
      axw(cwd_pkg::A_CMP0 + 8'h4, 32'h0, 4'h1, r);
      axw(cwd_pkg::A_CMP0 + 8'h4, {16'h0, hv[i], 8'h0}, 4'h2, r);
      axw(cwd_pkg::A_MOD0 + 8'h4, 32'h4a, 4'h1, r);
      v0 = modulePin[1];
      wait_pin(1, !v0, 600, n);
      wait_pin(1, v0, 600, n);
      chk_rng(n, (hv[i] == 8'h0) ? 256 : hv[i], (hv[i] == 8'h0) ? 256 : hv[i]);
    end
    $display("test frequency done");
  endtask

  task automatic t_pwm16;
    logic [1:0] r;
    int         n;
    axw(cwd_pkg::A_CMP0 + 8'h8, 32'hf0, 4'h1, r);
    axw(cwd_pkg::A_CMP0 + 8'h8, 32'hff00, 4'h2, r);
    axw(cwd_pkg::A_MOD0 + 8'h8, 32'hc2, 4'h1, r);
    // load the counter near the top instead of waiting a whole 16-bit period
    axw(cwd_pkg::A_CNT, 32'hff00, 4'h3, r);
    wait_pin(2, 1'b1, 400, n);
    wait_pin(2, 1'b0, 100, n); chk_rng(n, 16, 16);
    axw(cwd_pkg::A_CNT, 32'hff00, 4'h3, r);
    // new duty written just after the match, low byte first
    wait_pin(2, 1'b1, 400, n);
    axw(cwd_pkg::A_CMP0 + 8'h8, 32'h80, 4'h1, r);
    axw(cwd_pkg::A_CMP0 + 8'h8, 32'hff00, 4'h2, r);
    axw(cwd_pkg::A_CNT, 32'hff00, 4'h3, r);
    wait_pin(2, 1'b1, 400, n);
    wait_pin(2, 1'b0, 200, n); chk_rng(n, 128, 128);
    chk({29'h0, modulePin[5:3]}, 32'h0);
    $display("test pwm16 done");
  endtask

  task automatic t_tbase;
    logic [7:0]  md [6] = '{8'h02, 8'h04, 8'h06, 8'h0a, 8'h0c, 8'h88};
    int          lo [6] = '{39, 31, 19, 9, 0, 0};
    int          hi [6] = '{42, 34, 22, 12, 0, 0};
    logic [31:0] d0;
    logic [31:0] d1;
    logic [15:0] dl;
    logic [1:0]  r;
    // idle only matters for the last entry, which sets idle halt
    idle <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      axw(cwd_pkg::A_TBMD, {24'h0, md[i]}, 4'h1, r);
      axr(cwd_pkg::A_CNT, d0, r);
      repeat (160) @(posedge ref_clk);
      axr(cwd_pkg::A_CNT, d1, r);
      dl = d1[15:0] - d0[15:0];
      chk_rng(dl, lo[i], hi[i]);
    end
    idle <= 1'b0;
    $display("test timebase done");
  endtask

  task automatic t_wdog;
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    axw(cwd_pkg::A_CTRL, 32'h0, 4'h1, r);
    axw(cwd_pkg::A_CNT, 32'h0500, 4'h3, r);
    axw(cwd_pkg::A_CMP0 + 8'h14, 32'h02, 4'h1, r);
    axw(cwd_pkg::A_TBMD, 32'h48, 4'h1, r);
    axw(cwd_pkg::A_CMP0 + 8'h14, 32'hab00, 4'h2, r);
    t0 = cyc;
    axr(cwd_pkg::A_CMP0 + 8'h14, d, r); chk(d, 32'h0702);
    wait_pulse(1000); chk_rng(cyc - t0, 740, 775);
    wait_sys_reset();
    $display("test watchdog refresh done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    rstB = 1'b1;
    idle = 1'b0;
    req = '0;
    cyc = 0;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge ref_clk);
    rstB <= 1'b0;
    t_defaults();
    t_lock();
    wd_off();
    t_pwm8();
    t_freq();
    t_pwm16();
    t_tbase();
    t_wdog();
    close_out();
  end
endmodule
